/* File: twsp_host.sv */
// Behavioural two-wire bus master for the paged register slave
`timescale 1ns/10ps
module twsp_host (
    output logic      scl,
    output logic      pull,
    input  wire logic sda
);
    // Clock stands high between frames; 40 ns high, 85 ns low
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    // Waits out the slave's data hold before raising the clock
    task automatic start();
        pull = 1'b0;
        #80 scl = 1'b1;
        #40 pull = 1'b1;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #20 pull = 1'b1;
        #65 scl = 1'b1;
        #20 pull = 1'b0;
        #40;
    endtask
    // A one in d or ack_bit leaves the line released
    task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic acked);
        for (int i = 7; i >= -1; i--) begin
            #20 pull = (i >= 0) ? ~d[i] : ~ack_bit;
            #65 scl = 1'b1;
            #20 if (i >= 0) q[i] = sda; else acked = ~sda;
            #20 scl = 1'b0;
        end
    endtask
endmodule // twsp_host

/* File: twsp_pkg.sv */
// Constants, register map and carrier types for the paged two-wire slave
package twsp_pkg;

    // Clock and timing
    localparam int unsigned CLK_MHZ           = 100;
    localparam int unsigned CLK_KHZ           = 100_000;
    localparam int unsigned IDLE_TIMEOUT_MS   = 35;
    localparam int unsigned IDLE_TIMEOUT_CYC  = IDLE_TIMEOUT_MS * CLK_KHZ;
    localparam int unsigned STD_HOLD_NS       = 300;
    localparam int unsigned HS_HOLD_NS        = 20;
    localparam int unsigned STD_HOLD_CYC      = (STD_HOLD_NS * CLK_MHZ / 1000 < 1) ? 1 : STD_HOLD_NS * CLK_MHZ / 1000;
    localparam int unsigned HS_HOLD_CYC       = (HS_HOLD_NS * CLK_MHZ / 1000 < 1) ? 1 : HS_HOLD_NS * CLK_MHZ / 1000;
    localparam logic [4:0]  STD_HOLD_LD       = 5'(STD_HOLD_CYC);
    localparam logic [4:0]  HS_HOLD_LD        = 5'(HS_HOLD_CYC);
    localparam logic [3:0]  STUCK_PULSES      = 4'h9;

    // Two-wire protocol values
    localparam logic [7:0]  SLAVE_ADDR_DEFAULT = 8'hB0;
    localparam logic [4:0]  HS_MASTER_CODE     = 5'b0_0001;
    localparam logic [7:0]  PAGE0_VALUE        = 8'h00;
    localparam logic [7:0]  PAGE2_VALUE        = 8'h02;
    localparam logic [7:0]  PAGE_SEL_ADDR      = 8'h00;
    localparam logic [7:0]  REG_TOP_ADDR       = 8'h7F;

    // APB map
    localparam int unsigned APB_AW        = 12;
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] ADDR_OFFSET   = 12'h004;
    localparam logic [11:0] STATUS_OFFSET = 12'h008;

    // Control field positions and reset values
    localparam int unsigned CTRL_IF_EN_BIT    = 0;
    localparam int unsigned CTRL_TO_EN_BIT    = 1;
    localparam int unsigned CTRL_HS_CONT_BIT  = 2;
    localparam int unsigned CTRL_AUTO_RET_BIT = 3;
    localparam int unsigned CTRL_WR_MODE_BIT  = 4;
    localparam logic [4:0]  CTRL_RESET        = 5'h03;

    // Status field positions
    localparam int unsigned STAT_BUSY_BIT  = 0;
    localparam int unsigned STAT_HS_BIT    = 1;
    localparam int unsigned STAT_PAGE_BIT  = 2;
    localparam int unsigned STAT_DRIVE_BIT = 3;

    typedef struct packed {
        logic write_mode;
        logic page_auto_return;
        logic continuous_high_speed_ctrl;
        logic bus_idle_timeout_ctrl;
        logic if_enable;
    } twsp_ctrl_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } twsp_lines_t;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0011,
        ST_REG       = 4'b0010,
        ST_REG_ACK   = 4'b0110,
        ST_WDATA     = 4'b0111,
        ST_WDATA_ACK = 4'b0101,
        ST_TX        = 4'b0100,
        ST_TX_ACK    = 4'b1100,
        ST_IGNORE    = 4'b1101
    } twsp_state_t;

endpackage

/* File: twsp_slave.sv */
// Two-wire register slave with two register pages and an APB control port
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
module twsp_slave
    import twsp_pkg::*;
#(
    parameter int unsigned IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_CYC
) (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);

    ////////////////////////////////////////////////////////////////////////////
    // Line synchronisers and glitch filter

    twsp_lines_t sync1_reg, sync2_reg, sync3_reg;
    twsp_lines_t filt_reg, filt_next, filt_q_reg;

    always_comb begin
        filt_next = filt_reg;
        if (sync2_reg.scl == sync3_reg.scl) filt_next.scl = sync2_reg.scl;
        if (sync2_reg.sda == sync3_reg.sda) filt_next.sda = sync2_reg.sda;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg  <= '{scl: 1'b1, sda: 1'b1};
            sync2_reg  <= '{scl: 1'b1, sda: 1'b1};
            sync3_reg  <= '{scl: 1'b1, sda: 1'b1};
            filt_reg   <= '{scl: 1'b1, sda: 1'b1};
            filt_q_reg <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            sync1_reg  <= '{scl: scl_in, sda: sda_in};
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
            filt_reg   <= filt_next;
            filt_q_reg <= filt_reg;
        end
    end

    logic scl_rise, scl_fall, start_evt, stop_evt;
    assign scl_rise  = filt_reg.scl & ~filt_q_reg.scl;
    assign scl_fall  = ~filt_reg.scl & filt_q_reg.scl;
    assign start_evt = filt_reg.scl & filt_q_reg.scl & ~filt_reg.sda & filt_q_reg.sda;
    assign stop_evt  = filt_reg.scl & filt_q_reg.scl & filt_reg.sda & ~filt_q_reg.sda;

    ////////////////////////////////////////////////////////////////////////////
    // APB control port

    twsp_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] base_reg, base_next;
    logic       base_wr_reg, base_wr_next;
    logic [31:0] prdata_next;
    logic       pready_next, pslverr_next;
    logic [31:0] status_word;

    twsp_state_t st_reg, st_next;
    logic [7:0]  page_reg, page_next;
    logic        hs_reg, hs_next;

    assign status_word = {28'h000_0000, sda_oe, page_reg[1], hs_reg, st_reg != ST_IDLE};

    always_comb begin
        ctrl_next    = ctrl_reg;
        base_next    = base_reg;
        base_wr_next = base_wr_reg;
        prdata_next  = prdata;
        pslverr_next = 1'b0;
        // Zero wait states: answer is prepared during the setup cycle
        pready_next  = psel & ~penable;
        if (psel && !penable) begin
            case (paddr)
                CTRL_OFFSET:   prdata_next = {27'h000_0000, ctrl_reg};
                ADDR_OFFSET:   prdata_next = {24'h00_0000, base_reg};
                STATUS_OFFSET: prdata_next = status_word;
                default: begin
                    prdata_next  = 32'h0000_0000;
                    pslverr_next = 1'b1;
                end
            endcase
        end
        if (psel && penable && pready && pwrite) begin
            case (paddr)
                CTRL_OFFSET: ctrl_next = pwdata[4:0];
                ADDR_OFFSET: begin
                    base_next    = pwdata[7:0];
                    base_wr_next = 1'b1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg    <= CTRL_RESET;
            base_reg    <= SLAVE_ADDR_DEFAULT;
            base_wr_reg <= 1'b0;
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            base_reg    <= base_next;
            base_wr_reg <= base_wr_next;
            prdata      <= prdata_next;
            pready      <= pready_next;
            pslverr     <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register pages

    logic [7:0] mem [0:255];
    logic       mem_we;
    logic [7:0] mem_idx, mem_wdata;
    logic [7:0] ptr_reg, ptr_next;
    logic       ptr_exists;
    logic [7:0] rd_byte;

    // Only the lower half of each page is populated
    assign ptr_exists = (ptr_reg != PAGE_SEL_ADDR) && (ptr_reg <= REG_TOP_ADDR);

    always_comb begin
        if (ptr_reg == PAGE_SEL_ADDR) rd_byte = page_reg;
        else if (ptr_exists)          rd_byte = mem[{page_reg[1], ptr_reg[6:0]}];
        else                          rd_byte = 8'h00;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
        end else if (mem_we) begin
            mem[mem_idx] <= mem_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protocol engine

    logic [3:0]  bitcnt_reg, bitcnt_next;
    logic [7:0]  shift_reg, shift_next;
    logic [7:0]  txsh_reg, txsh_next;
    logic        rw_reg, rw_next;
    logic        first_reg, first_next;
    logic        drv_reg, drv_next;
    logic        mack_reg, mack_next;
    logic [1:0]  rev_reg, rev_next;
    logic [3:0]  stuck_reg, stuck_next;
    logic [21:0] idle_cnt_reg, idle_cnt_next;
    logic [4:0]  hold_reg, hold_next;
    logic        sda_oe_next;
    logic        abort;

    assign abort = !ctrl_reg.if_enable
                 || (stuck_reg == STUCK_PULSES)
                 || (ctrl_reg.bus_idle_timeout_ctrl
                     && idle_cnt_reg == 22'(IDLE_TIMEOUT_CYCLES - 1));

    always_comb begin
        st_next       = st_reg;
        bitcnt_next   = bitcnt_reg;
        shift_next    = shift_reg;
        txsh_next     = txsh_reg;
        ptr_next      = ptr_reg;
        page_next     = page_reg;
        rw_next       = rw_reg;
        first_next    = first_reg;
        hs_next       = hs_reg | ctrl_reg.continuous_high_speed_ctrl;
        drv_next      = drv_reg;
        mack_next     = mack_reg;
        rev_next      = rev_reg;
        mem_we        = 1'b0;
        mem_idx       = {page_reg[1], ptr_reg[6:0]};
        mem_wdata     = shift_reg;
        stuck_next    = stuck_reg;
        idle_cnt_next = (st_reg == ST_IDLE || scl_rise || scl_fall) ? 22'h00_0000 : 22'(idle_cnt_reg + 1'b1);
        if (scl_rise) begin
            shift_next  = {shift_reg[6:0], filt_reg.sda};
            bitcnt_next = 4'(bitcnt_reg + 1'b1);
            // Zeros we send on purpose, our own ACKs or the master's ACK are not a stuck line;
            // otherwise a zero data byte plus our ACK would look like nine stuck pulses
            if (!filt_reg.sda && !sda_oe && st_reg != ST_TX && st_reg != ST_TX_ACK) stuck_next = 4'(stuck_reg + 1'b1);
            else stuck_next = 4'h0;
            if (st_reg == ST_TX_ACK) begin
                mack_next = ~filt_reg.sda;
                if (!filt_reg.sda) ptr_next = 8'(ptr_reg + 1'b1);
            end
        end
        if (abort) begin
            st_next    = ST_IDLE;
            drv_next   = 1'b0;
            stuck_next = 4'h0;
            hs_next    = ctrl_reg.continuous_high_speed_ctrl;
        end else if (stop_evt) begin
            st_next    = ST_IDLE;
            drv_next   = 1'b0;
            stuck_next = 4'h0;
            hs_next    = ctrl_reg.continuous_high_speed_ctrl;
            if (rev_reg == 2'b01) rev_next = 2'b10;
            else if (rev_reg == 2'b10) begin
                rev_next  = 2'b00;
                page_next = PAGE0_VALUE;
            end
        end else if (start_evt) begin
            // Pointer survives a repeated START so a read follows the write
            st_next     = ST_ADDR;
            first_next  = (st_reg == ST_IDLE);
            bitcnt_next = 4'h0;
            drv_next    = 1'b0;
            stuck_next  = 4'h0;
        end else if (scl_fall) begin
            case (st_reg)
                ST_ADDR: if (bitcnt_reg == 4'h8) begin
                    first_next = 1'b0;
                    if (first_reg && shift_reg[7:3] == HS_MASTER_CODE) begin
                        hs_next = 1'b1;
                        st_next = ST_IGNORE;
                    end else if (shift_reg[7:2] == base_reg[7:2]) begin
                        drv_next  = 1'b1;
                        st_next   = ST_ADDR_ACK;
                        rw_next   = shift_reg[0];
                        page_next = shift_reg[1] ? PAGE2_VALUE : PAGE0_VALUE;
                    end else begin
                        st_next = ST_IGNORE;
                    end
                end
                ST_ADDR_ACK: begin
                    bitcnt_next = 4'h0;
                    if (rw_reg) begin
                        txsh_next = rd_byte;
                        drv_next  = ~rd_byte[7];
                        st_next   = ST_TX;
                    end else begin
                        drv_next = 1'b0;
                        st_next  = ST_REG;
                    end
                end
                ST_REG: if (bitcnt_reg == 4'h8) begin
                    ptr_next = shift_reg;
                    drv_next = 1'b1;
                    st_next  = ST_REG_ACK;
                end
                ST_REG_ACK, ST_WDATA_ACK: begin
                    bitcnt_next = 4'h0;
                    drv_next    = 1'b0;
                    st_next     = (st_reg == ST_WDATA_ACK && ctrl_reg.write_mode) ? ST_REG : ST_WDATA;
                end
                ST_WDATA: if (bitcnt_reg == 4'h8) begin
                    if (ptr_reg == PAGE_SEL_ADDR) begin
                        page_next = {shift_reg[7:1], 1'b0};
                        rev_next  = ctrl_reg.page_auto_return ? 2'b01 : 2'b00;
                    end else if (ptr_exists) begin
                        mem_we = 1'b1;
                    end
                    if (!ctrl_reg.write_mode) ptr_next = 8'(ptr_reg + 1'b1);
                    drv_next = 1'b1;
                    st_next  = ST_WDATA_ACK;
                end
                ST_TX: begin
                    if (bitcnt_reg == 4'h8) begin
                        drv_next = 1'b0;
                        st_next  = ST_TX_ACK;
                    end else begin
                        txsh_next = {txsh_reg[6:0], 1'b0};
                        drv_next  = ~txsh_reg[6];
                    end
                end
                ST_TX_ACK: begin
                    bitcnt_next = 4'h0;
                    if (mack_reg) begin
                        txsh_next = rd_byte;
                        drv_next  = ~rd_byte[7];
                        st_next   = ST_TX;
                    end else begin
                        st_next = ST_IGNORE;
                    end
                end
                default: ;
            endcase
        end
    end

    // Output follows the wanted level after a hold delay; a long delay
    // would eat the short low phase at high speed, so it shrinks there
    always_comb begin
        hold_next   = hold_reg;
        sda_oe_next = sda_oe;
        if (scl_fall) hold_next = hs_reg ? HS_HOLD_LD : STD_HOLD_LD;
        else if (hold_reg != 5'h00) hold_next = 5'(hold_reg - 1'b1);
        if (abort || stop_evt || start_evt) begin
            sda_oe_next = 1'b0;
            hold_next   = 5'h00;
        end else if (hold_reg == 5'h01) begin
            sda_oe_next = drv_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg       <= ST_IDLE;
            bitcnt_reg   <= 4'h0;
            shift_reg    <= 8'h00;
            txsh_reg     <= 8'h00;
            ptr_reg      <= 8'h00;
            page_reg     <= PAGE0_VALUE;
            rw_reg       <= 1'b0;
            first_reg    <= 1'b0;
            hs_reg       <= 1'b0;
            drv_reg      <= 1'b0;
            mack_reg     <= 1'b0;
            rev_reg      <= 2'b00;
            stuck_reg    <= 4'h0;
            idle_cnt_reg <= 22'h00_0000;
            hold_reg     <= 5'h00;
            sda_oe       <= 1'b0;
            sda_out      <= 1'b0;
        end else begin
            st_reg       <= st_next;
            bitcnt_reg   <= bitcnt_next;
            shift_reg    <= shift_next;
            txsh_reg     <= txsh_next;
            ptr_reg      <= ptr_next;
            page_reg     <= page_next;
            rw_reg       <= rw_next;
            first_reg    <= first_next;
            hs_reg       <= hs_next;
            drv_reg      <= drv_next;
            mack_reg     <= mack_next;
            rev_reg      <= rev_next;
            stuck_reg    <= stuck_next;
            idle_cnt_reg <= idle_cnt_next;
            hold_reg     <= hold_next;
            sda_oe       <= sda_oe_next;
            sda_out      <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    chk_default_addr: assert property (!base_wr_reg |-> base_reg == SLAVE_ADDR_DEFAULT)
        else $error("Slave address changed without a write");
    chk_own_addr_ack: assert property (
        (st_reg == ST_ADDR && scl_fall && bitcnt_reg == 4'h8 && !abort && !(first_reg && shift_reg[7:3] == HS_MASTER_CODE)
         && shift_reg[7:2] == base_reg[7:2]) |=> ##[1:31] sda_oe)
        else $error("Own address not acknowledged");
    chk_timeout_idle: assert property (
        (ctrl_reg.bus_idle_timeout_ctrl && idle_cnt_reg == 22'(IDLE_TIMEOUT_CYCLES - 1)) |=> st_reg == ST_IDLE && !sda_oe)
        else $error("Idle clock timeout did not reset interface");
    chk_stuck_release: assert property ((stuck_reg == STUCK_PULSES) |=> st_reg == ST_IDLE && !sda_oe)
        else $error("Stuck line not released after nine pulses");
    chk_hs_master_code: assert property (
        (st_reg == ST_ADDR && scl_fall && bitcnt_reg == 4'h8 && first_reg && !abort && !start_evt && !stop_evt
         && shift_reg[7:3] == HS_MASTER_CODE) |=> hs_reg && st_reg == ST_IGNORE)
        else $error("Master code did not enter high speed");
    chk_hs_continuous: assert property (ctrl_reg.continuous_high_speed_ctrl [*2] |-> hs_reg)
        else $error("Continuous high speed not applied");
    chk_page_lsb: assert property (page_reg[0] == 1'b0)
        else $error("Page value holds its low bit");
    chk_stop_abort: assert property (stop_evt |=> st_reg == ST_IDLE ##1 !sda_oe)
        else $error("Stop did not return to idle");
    chk_read_incr: assert property (
        (st_reg == ST_TX_ACK && scl_rise && !filt_reg.sda) |=> ptr_reg == 8'($past(ptr_reg) + 1'b1))
        else $error("Pointer not advanced after master ACK");
    chk_absent_zero: assert property ((ptr_reg > REG_TOP_ADDR) |-> rd_byte == 8'h00)
        else $error("Absent register reads nonzero");

endmodule // twsp_slave

/* File: twsp_slave_tb.sv */
// Self-checking bench: APB control plus random paged traffic over the link
`timescale 1ns/10ps
module twsp_slave_tb import twsp_pkg::*; ;
    logic        core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q32, v;
    logic        pready, pslverr, sda_out, sda_oe, scl, pull, acked, berr;
    logic [7:0]  q, r, mem [0:1][0:255];
    int          error_cnt = 0, checked = 0, cyc = 0, seed = 32'hdc13_ad41;
    wire         sda = (pull | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
    twsp_slave #(.IDLE_TIMEOUT_CYCLES(200)) DUT (.core_clk(core_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    twsp_host host (.scl(scl), .pull(pull), .sda(sda));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("BAD apb pready expected 1 seen %b", pready);
        end
        q32 = prdata;
        berr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] exp_rd(input logic p, input logic [7:0] a);
        return a[7] ? 8'h00 : mem[p][a];
    endfunction
    task automatic tw_wr(input logic [7:0] sa, input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
        host.start();
        host.xfer(sa, 1'b1, q, acked);
        chk("addr ack", 1, acked);
        host.xfer(a, 1'b1, q, acked);
        host.xfer(d0, 1'b1, q, acked);
        host.xfer(d1, 1'b1, q, acked);
        chk("data ack", 1, acked);
        host.stop();
        mem[sa[1]][a] = d0;
        mem[sa[1]][a + 8'h01] = d1;
    endtask
    task automatic tw_rd(input logic [7:0] sa, input logic [7:0] a);
        host.start();
        host.xfer(sa & 8'hFE, 1'b1, q, acked);
        host.xfer(a, 1'b1, q, acked);
        host.start();
        host.xfer(sa | 8'h01, 1'b1, q, acked);
        host.xfer(8'hFF, 1'b0, q, acked);
        chk("read first", exp_rd(sa[1], a), q);
        host.xfer(8'hFF, 1'b1, q, acked);
        chk("read next", exp_rd(sa[1], a + 8'h01), q);
        host.stop();
    endtask
    initial begin
        for (int i = 0; i < 512; i++) mem[i / 256][i % 256] = 8'h00;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        apb(1'b0, CTRL_OFFSET, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0003, q32);
        apb(1'b0, ADDR_OFFSET, 32'h0000_0000);
        chk("addr reset", 32'h0000_00B0, q32);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("unmapped err", 1, berr);
        // Host's short low phase needs the fast data hold
        apb(1'b1, CTRL_OFFSET, 32'h0000_0007);
        $display("apb test done");
        repeat (6) begin
            v = $random(seed);
            r = 8'h01 + 8'(v[6:0] % 7'd126);
            tw_wr(8'hB0 | {6'h00, v[24], 1'b0}, r, v[15:8], v[23:16]);
            tw_rd(8'hB0 | {6'h00, v[25], 1'b0}, r);
        end
        tw_rd(8'hB2, 8'h7F);
        tw_rd(8'hB0, 8'h00);
        $display("paged traffic test done");
        host.start();
        host.xfer(8'hA0, 1'b1, q, acked);
        chk("foreign addr nack", 0, acked);
        host.stop();
        host.start();
        host.xfer(8'h08, 1'b1, q, acked);
        chk("master code nack", 0, acked);
        host.stop();
        host.start();
        host.xfer(8'hB0, 1'b1, q, acked);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk("busy mid frame", 1, q32[STAT_BUSY_BIT]);
        repeat (400) @(posedge core_clk);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk("busy after idle clock", 0, q32[STAT_BUSY_BIT]);
        host.stop();
        $display("address and timeout test done");
        tally_and_finish();
    end
endmodule // twsp_slave_tb
